// File: rtl/wcmp1_top.sv
`timescale 1ns/1ps
`include "wcmp1_params.svh"
// Function
// - Value-compare fields read zero, ignore writes
// - Reserved upper bits read zero, unwritable
// - Hit flag set on selected access type
// - Reading function register clears hit flag
// - Four-bit action field; zero disables
// - Mask widens paired match to address range
// - Hits issue trace begin/halt requests
// - Requests honoured only when enabled
// - Begin wins over simultaneous halt
// - Decode fetch, read, write, read-or-write
// - Comparator 1 compares addresses only
// - Action bit picks halt or begin
module wcmp1_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire wcmp1_pkg::wcmp1_mon_t mon,
  input wire logic cmp0_begin_req,
  input wire logic cmp0_halt_req,
  output logic trace_begin_req,
  output logic trace_halt_req,
  output logic trace_recording,
  output logic pair_addr_match,
  output logic irq
);

  // =====================================================
  // Registers
  // =====================================================
  logic [31:0] comparator1_value;
  logic [`WC_MASK_MSB:0] comparator1_mask;
  logic [`WC_FN_MSB:0] fn;
  logic cmp_hit_flag;
  logic cmp1_trace_action;
  logic trace_begin_enable;
  logic trace_halt_enable;
  logic [`WC_IRQ_W-1:0] irq_status;
  logic [`WC_IRQ_W-1:0] irq_mask;
  wcmp1_pkg::wcmp1_rec_t rec_state;

  // =====================================================
  // AHB-Lite slave
  // =====================================================
  logic addr_ok;
  logic rd_take;
  logic wr_pend;
  logic [4:0] wr_off;
  logic [4:0] a_off;
  logic fn_read;
  logic [31:0] next_rdata;

  // Zero-wait slave: every transfer ends in one data phase
  assign addr_ok = hsel && htrans[1] && hready;
  assign a_off = haddr[4:0];
  assign rd_take = addr_ok && !hwrite;
  assign fn_read = rd_take && (a_off == `WC_OFF_FUNC);

  // Always OKAY with no wait; write address phase latched for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_off <= 5'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_ok && hwrite;
      wr_off <= a_off;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    next_rdata = 32'h0;
    unique case (a_off)
      `WC_OFF_VALUE: next_rdata = comparator1_value;
      `WC_OFF_MASK: next_rdata[`WC_MASK_MSB:0] = comparator1_mask;
      // value bits and reserved read zero
      `WC_OFF_FUNC:
      begin
        next_rdata[`WC_HIT_BIT] = cmp_hit_flag;
        next_rdata[`WC_FN_MSB:0] = fn;
      end
      `WC_OFF_TCTL: next_rdata[`WC_ACT_BIT] = cmp1_trace_action;
      `WC_OFF_MCTL:
      begin
        next_rdata[`WC_BEN_BIT] = trace_begin_enable;
        next_rdata[`WC_HEN_BIT] = trace_halt_enable;
        next_rdata[`WC_REC_BIT] = trace_recording;
      end
      `WC_OFF_IST: next_rdata[`WC_IRQ_W-1:0] = irq_status;
      `WC_OFF_IMSK: next_rdata[`WC_IRQ_W-1:0] = irq_mask;
      default: next_rdata = 32'h0;
    endcase
  end

  // Read data presented in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (rd_take)
      hrdata <= next_rdata;
  end

  // Writable fields; the status register is write-one-to-clear below, everything else ignores writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      comparator1_value <= 32'h0;
      comparator1_mask <= '0;
      fn <= `WC_FN_DIS;
      cmp1_trace_action <= 1'b0;
      trace_begin_enable <= 1'b0;
      trace_halt_enable <= 1'b0;
      irq_mask <= '0;
    end
    else if (wr_pend)
    begin
      unique case (wr_off)
        `WC_OFF_VALUE: comparator1_value <= hwdata;
        `WC_OFF_MASK: comparator1_mask <= hwdata[`WC_MASK_MSB:0];
        `WC_OFF_FUNC: fn <= hwdata[`WC_FN_MSB:0];
        `WC_OFF_TCTL: cmp1_trace_action <= hwdata[`WC_ACT_BIT];
        `WC_OFF_MCTL:
        begin
          trace_begin_enable <= hwdata[`WC_BEN_BIT];
          trace_halt_enable <= hwdata[`WC_HEN_BIT];
        end
        `WC_OFF_IMSK: irq_mask <= hwdata[`WC_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // =====================================================
  // Address comparator
  // =====================================================
  logic [31:0] care;
  logic addr_eq;
  logic type_ok;
  logic hit_now;

  // mask clears low address bits from compare
  assign care = ~((32'h1 << comparator1_mask) - 32'h1);
  assign addr_eq = ((mon.addr ^ comparator1_value) & care) == 32'h0;
  // access type decode; reserved codes never match
  always_comb
  begin
    type_ok = 1'b0;
    unique case (fn)
      `WC_FN_FETCH: type_ok = mon.fetch;
      `WC_FN_RD: type_ok = !mon.fetch && !mon.write;
      `WC_FN_WR: type_ok = !mon.fetch && mon.write;
      `WC_FN_RW: type_ok = !mon.fetch;
      default: type_ok = 1'b0;
    endcase
  end
  assign hit_now = mon.valid && addr_eq && type_ok;
  // sticky hit, a new hit beats the read clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmp_hit_flag <= 1'b0;
    else if (hit_now)
      cmp_hit_flag <= 1'b1;
    else if (fn_read)
      cmp_hit_flag <= 1'b0;
  end

  // range match offered to comparator 0 pairing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pair_addr_match <= 1'b0;
    else
      pair_addr_match <= mon.valid && addr_eq;
  end

  // =====================================================
  // Trace trigger path
  // =====================================================
  logic begin_any;
  logic halt_any;

  // one-cycle request chosen by action bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trace_begin_req <= 1'b0;
      trace_halt_req <= 1'b0;
    end
    else
    begin
      trace_begin_req <= hit_now && cmp1_trace_action;
      trace_halt_req <= hit_now && !cmp1_trace_action;
    end
  end

  assign begin_any = (trace_begin_req || cmp0_begin_req) && trace_begin_enable;
  assign halt_any = (trace_halt_req || cmp0_halt_req) && trace_halt_enable;

  // begin checked first so it wins a tie
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rec_state <= wcmp1_pkg::WC_IDLE;
    else if (begin_any)
      rec_state <= wcmp1_pkg::WC_REC;
    else if (halt_any)
      rec_state <= wcmp1_pkg::WC_IDLE;
  end

  // Recording flag kept as its own flop for the pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      trace_recording <= 1'b0;
    else if (begin_any)
      trace_recording <= 1'b1;
    else if (halt_any)
      trace_recording <= 1'b0;
  end

  // =====================================================
  // Interrupts
  // =====================================================
  logic [`WC_IRQ_W-1:0] ev;
  logic ist_wr;

  assign ev[`WC_IST_HIT] = hit_now;
  assign ev[`WC_IST_BEG] = begin_any && (rec_state == wcmp1_pkg::WC_IDLE);
  assign ev[`WC_IST_HLT] = !begin_any && halt_any && (rec_state == wcmp1_pkg::WC_REC);
  assign ist_wr = wr_pend && (wr_off == `WC_OFF_IST);

  // Write one to clear; an event in the same cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < `WC_IRQ_W; gi++)
    begin : g_ist
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          irq_status[gi] <= 1'b0;
        else if (ev[gi])
          irq_status[gi] <= 1'b1;
        else if (ist_wr && hwdata[gi])
          irq_status[gi] <= 1'b0;
      end
    end
  endgenerate

  // Level interrupt, one cycle behind the status
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // =====================================================
  // Assertions
  // =====================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_hit_set;
    hit_now |=> cmp_hit_flag;
  endproperty
  a_hit_set: assert property (p_hit_set) else $error("hit flag not set");
  property p_hit_clr;
    fn_read && !hit_now |=> !cmp_hit_flag;
  endproperty
  a_hit_clr: assert property (p_hit_clr) else $error("hit flag not cleared by read");
  property p_rsv_zero;
    fn_read |=> hrdata[31:25] == 7'h0 && hrdata[23:4] == 20'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");
  property p_disabled;
    fn == `WC_FN_DIS |=> !trace_begin_req && !trace_halt_req;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled comparator fired");
  property p_begin_sel;
    hit_now && cmp1_trace_action |=> trace_begin_req && !trace_halt_req;
  endproperty
  a_begin_sel: assert property (p_begin_sel) else $error("begin not issued");
  property p_halt_sel;
    hit_now && !cmp1_trace_action |=> trace_halt_req && !trace_begin_req;
  endproperty
  a_halt_sel: assert property (p_halt_sel) else $error("halt not issued");
  property p_begin_pri;
    begin_any && halt_any |=> trace_recording;
  endproperty
  a_begin_pri: assert property (p_begin_pri) else $error("begin lost to halt");
  property p_gate;
    !trace_begin_enable && !trace_halt_enable |=> $stable(trace_recording);
  endproperty
  a_gate: assert property (p_gate) else $error("disabled request acted on");
  property p_fetch_only;
    fn == `WC_FN_FETCH && mon.valid && !mon.fetch |-> !hit_now;
  endproperty
  a_fetch_only: assert property (p_fetch_only) else $error("data access hit fetch mode");
  property p_irq;
    |(irq_status & irq_mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  c_begin: cover property (hit_now && cmp1_trace_action ##2 trace_recording);
  c_tie: cover property (begin_any && halt_any);
  c_set_clr: cover property (hit_now && fn_read);
endmodule

// File: rtl/wcmp1_params.svh
`ifndef WCMP1_PARAMS_SVH
`define WCMP1_PARAMS_SVH
// Register byte offsets
`define WC_OFF_VALUE 5'h00
`define WC_OFF_MASK 5'h04
`define WC_OFF_FUNC 5'h08
`define WC_OFF_TCTL 5'h0c
`define WC_OFF_MCTL 5'h10
`define WC_OFF_IST 5'h14
`define WC_OFF_IMSK 5'h18
// Function register fields
`define WC_HIT_BIT 24
`define WC_FN_MSB 3
`define WC_FN_DIS 4'h0
`define WC_FN_FETCH 4'h4
`define WC_FN_RD 4'h5
`define WC_FN_WR 4'h6
`define WC_FN_RW 4'h7
// Control fields
`define WC_ACT_BIT 1
`define WC_BEN_BIT 0
`define WC_HEN_BIT 1
`define WC_REC_BIT 2
`define WC_MASK_MSB 4
// Status bits: hit, began, halted
`define WC_IRQ_W 3
`define WC_IST_HIT 0
`define WC_IST_BEG 1
`define WC_IST_HLT 2
`endif

// File: rtl/wcmp1_pkg.sv
package wcmp1_pkg;
  // One observed processor bus access
  typedef struct packed {
    logic valid;
    logic fetch;
    logic write;
    logic [31:0] addr;
  } wcmp1_mon_t;
  // Trace recording state
  typedef enum logic [1:0] {
    WC_IDLE = 2'b01,
    WC_REC = 2'b10
  } wcmp1_rec_t;
endpackage

// File: bench/wcmp1_bus_model.sv
`timescale 1ns/1ps
// ==========
// Processor bus monitor model
module wcmp1_bus_model (
  input wire logic hclk,
  output wcmp1_pkg::wcmp1_mon_t mon
);
  // Idle bus shows no access
  initial mon = '0;
  // One access for one cycle; the address is then inverted so stale values never match
  task automatic access(input logic f, input logic w, input logic [31:0] a);
    @(posedge hclk);
    mon <= {1'b1, f, w, a};
    @(posedge hclk);
    mon <= {1'b0, f, w, ~a};
  endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "wcmp1_params.svh"
// ==========
// Watchpoint comparator testbench
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic cb = 1'b0;
  logic ch = 1'b0;
  logic hreadyout, hresp, bg, hl, rec, pam, irq;
  logic [31:0] hrdata, rd;
  wcmp1_pkg::wcmp1_mon_t mon;
  int error_cnt = 0;
  int tests_run = 0;
  // Clock, 5 ns period
  always #2.5 hclk = ~hclk;
  wcmp1_top i_wcmp1_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mon(mon), .cmp0_begin_req(cb),
    .cmp0_halt_req(ch), .trace_begin_req(bg), .trace_halt_req(hl), .trace_recording(rec),
    .pair_addr_match(pam), .irq(irq));
  wcmp1_bus_model i_wcmp1_bus_model (.hclk(hclk), .mon(mon));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded wait for ready; a hang ends the run
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        error_cnt++;
        $display("[FAIL] %0t bus hang", $time);
        final_report();
      end
      @(posedge hclk);
    end
  endtask
  // Single word transfer, read data taken at the data phase edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic acc(input logic f, input logic w, input logic [31:0] a);
    i_wcmp1_bus_model.access(f, w, a);
    #1;
  endtask
  task automatic t_reset();
    bus(1'b0, `WC_OFF_FUNC, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 5'h1c, 32'h0);
    chk(rd, 32'h0);
    chk({hresp, irq}, 32'h0);
    bus(1'b1, `WC_OFF_FUNC, 32'hffff_fff4);
    bus(1'b0, `WC_OFF_FUNC, 32'h0);
    chk(rd, 32'h4);
    $display("reset and fields done");
  endtask
  // Action codes 0 and 4 to 7 against every access type
  task automatic t_decode();
    logic [3:0] c [5];
    logic e;
    c = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7};
    bus(1'b1, `WC_OFF_VALUE, 32'h2000_0040);
    bus(1'b1, `WC_OFF_MASK, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      for (int t = 0; t < 3; t++)
      begin
        e = (c[i] == 4'h4 && t == 0) || (c[i] == 4'h5 && t == 1) || (c[i] == 4'h6 && t == 2)
          || (c[i] == 4'h7 && t != 0);
        bus(1'b1, `WC_OFF_FUNC, {28'h0, c[i]});
        acc(t == 0, t == 2, 32'h2000_0040);
        bus(1'b0, `WC_OFF_FUNC, 32'h0);
        chk(rd, {7'h0, e, 20'h0, c[i]});
        bus(1'b0, `WC_OFF_FUNC, 32'h0);
        chk(rd, {28'h0, c[i]});
      end
    end
    $display("decode done");
  endtask
  // Paired setup keeps the action at zero; mask widens the range
  task automatic t_mask();
    bus(1'b1, `WC_OFF_MASK, 32'h4);
    bus(1'b1, `WC_OFF_FUNC, 32'h0);
    acc(1'b0, 1'b0, 32'h2000_004f);
    chk(pam, 32'h1);
    bus(1'b1, `WC_OFF_FUNC, 32'h5);
    acc(1'b0, 1'b0, 32'h2000_0050);
    chk(pam, 32'h0);
    bus(1'b0, `WC_OFF_FUNC, 32'h0);
    chk(rd, 32'h5);
    acc(1'b0, 1'b0, 32'h2000_0044);
    bus(1'b0, `WC_OFF_FUNC, 32'h0);
    chk(rd, 32'h0100_0005);
    bus(1'b0, `WC_OFF_MASK, 32'h0);
    chk(rd, 32'h4);
    bus(1'b0, `WC_OFF_VALUE, 32'h0);
    chk(rd, 32'h2000_0040);
    $display("mask done");
  endtask
  task automatic t_trig();
    bus(1'b1, `WC_OFF_MASK, 32'h0);
    bus(1'b1, `WC_OFF_FUNC, 32'h4);
    bus(1'b1, `WC_OFF_MCTL, 32'h3);
    bus(1'b1, `WC_OFF_TCTL, 32'h2);
    acc(1'b1, 1'b0, 32'h2000_0040);
    chk({bg, hl}, 32'h2);
    @(posedge hclk);
    #1;
    chk({bg, rec}, 32'h1);
    bus(1'b0, `WC_OFF_MCTL, 32'h0);
    chk(rd, 32'h7);
    bus(1'b1, `WC_OFF_TCTL, 32'h0);
    acc(1'b1, 1'b0, 32'h2000_0040);
    chk({bg, hl}, 32'h1);
    @(posedge hclk);
    #1;
    chk(rec, 32'h0);
    bus(1'b1, `WC_OFF_MCTL, 32'h0);
    bus(1'b1, `WC_OFF_TCTL, 32'h2);
    acc(1'b1, 1'b0, 32'h2000_0040);
    repeat (2) @(posedge hclk);
    #1;
    chk(rec, 32'h0);
    bus(1'b1, `WC_OFF_MCTL, 32'h3);
    @(posedge hclk);
    cb <= 1'b1;
    ch <= 1'b1;
    @(posedge hclk);
    cb <= 1'b0;
    ch <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk(rec, 32'h1);
    bus(1'b0, `WC_OFF_IST, 32'h0);
    chk(rd, 32'h7);
    $display("trigger done");
  endtask
  // Interrupt raised, cleared, then masked
  task automatic t_irq();
    bus(1'b1, `WC_OFF_IST, 32'h7);
    bus(1'b1, `WC_OFF_IMSK, 32'h1);
    repeat (2) @(posedge hclk);
    #1;
    chk(irq, 32'h0);
    acc(1'b1, 1'b0, 32'h2000_0040);
    repeat (2) @(posedge hclk);
    #1;
    chk(irq, 32'h1);
    bus(1'b1, `WC_OFF_IST, 32'h1);
    repeat (2) @(posedge hclk);
    #1;
    chk(irq, 32'h0);
    bus(1'b1, `WC_OFF_IMSK, 32'h0);
    acc(1'b1, 1'b0, 32'h2000_0040);
    repeat (2) @(posedge hclk);
    #1;
    chk(irq, 32'h0);
    bus(1'b0, `WC_OFF_IST, 32'h0);
    chk(rd, 32'h1);
    $display("interrupt done");
  endtask
  // Reset in mid-run must drop the hit flag, the action field and recording
  task automatic t_rst_mid();
    bus(1'b1, `WC_OFF_FUNC, 32'h4);
    acc(1'b1, 1'b0, 32'h2000_0040);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk({rec, irq}, 32'h0);
    bus(1'b0, `WC_OFF_FUNC, 32'h0);
    chk(rd, 32'h0);
    $display("mid-run reset done");
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_decode();
    t_mask();
    t_trig();
    t_irq();
    t_rst_mid();
    final_report();
  end
endmodule
